// >>> sim/nvs_bus_master.sv
`timescale 1ns/10ps

// ******************************
// Two-wire bus master model
// ******************************
module nvs_bus_master (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_oe
);
  // The bus idles with the clock high and data released.
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // Lines move just after an edge and then hold for n edges.
  task step(input s, input d, input integer n);
    begin
      @(posedge clk);
      scl    <= s;
      sda_oe <= d;
      repeat (n - 1) @(posedge clk);
    end
  endtask

  // Data moves only mid low phase; it is read late in the high phase.
  task xbit(input d, output r);
    begin
      step(1'b0, sda_oe, 2);
      step(1'b0, ~d, 2);
      step(1'b1, ~d, 4);
      r = sda;
    end
  endtask

  // Start or repeated start: data falls while the clock is high.
  task start_c;
    begin
      step(1'b0, sda_oe, 2);
      step(1'b0, 1'b0, 2);
      step(1'b1, 1'b0, 2);
      step(1'b1, 1'b1, 4);
    end
  endtask

  // Stop is only made while the master owns the data line.
  task stop_c;
    begin
      step(1'b0, sda_oe, 2);
      step(1'b0, 1'b1, 2);
      step(1'b1, 1'b1, 2);
      step(1'b1, 1'b0, 8);
    end
  endtask

  // A byte MSB first and its slot; n below 8 leaves a partial byte.
  task xfer(input [7:0] b, input integer n, input slot, output [7:0] r, output a);
    integer i;
    begin
      r = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        xbit(b[i], r[i]);
      end
      a = 1'b1;
      if (n == 8) begin
        xbit(slot, a);
      end
    end
  endtask
endmodule  // nvs_bus_master

// >>> sim/nvs_slave_props.sv
`timescale 1ns/10ps

// ******************************
// Bus checker beside the slave
// ******************************
module nvs_slave_props (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Start and stop are data edges seen while the clock stays high.
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out is not held low");
  a_oe_low_phase: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda_oe moved outside the low clock phase");
  a_scl_high_hold: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda_oe moved while the clock was high");
  a_drive_needs_active: assert property (sda_oe |-> active)
    else $error("slave drives data while not addressed");
  a_start_wakes: assert property (scl_in && $past(scl_in) && $fell(sda_in)
    |-> ##[1:6] active) else $error("start did not raise active");
  a_stop_idles: assert property (scl_in && $past(scl_in) && $rose(sda_in)
    |-> ##[1:6] !active) else $error("stop did not clear active");
  a_restart_keeps: assert property (active && scl_in && $past(scl_in) && $fell(sda_in)
    |=> active [*6]) else $error("repeated start dropped active");
  a_stop_release: assert property (scl_in && $past(scl_in) && $rose(sda_in)
    |=> (!sda_oe) [*6]) else $error("slave drove data after stop");

  // Main scenarios reached.
  c_drive: cover property (sda_oe && scl_in);
  c_stop: cover property (scl_in && $past(scl_in) && $rose(sda_in));
  c_restart: cover property (active && scl_in && $past(scl_in) && $fell(sda_in));
endmodule  // nvs_slave_props

// >>> sim/nvs_slave_tb_top.sv
`timescale 1ns/10ps

bind nvs_slave nvs_slave_props u_props (.clk(clk), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .active(active));

// ******************************
// Slave bench
// ******************************
module nvs_slave_tb_top;
  localparam [3:0] TYPE = 4'h6;  // Arbitrary device type code.
  reg        clk         = 1'b0;
  reg        reset_n     = 1'b0;
  reg        wp          = 1'b0;
  reg        sel_hi      = 1'b1;
  reg        sel_lo      = 1'b0;
  integer    n_fail      = 0;
  integer    comparisons = 0;
  reg  [7:0] rd;
  reg  [7:0] k;
  reg        a;
  wire       scl;
  wire       m_oe;
  wire       d_oe;
  wire       d_out;
  wire       act;
  // Pulled-up wire: low whenever either side pulls it.
  wire       sda = !m_oe && (d_oe ? d_out : 1'b1);

  always #50 clk = ~clk;

  nvs_bus_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  nvs_slave #(.DEV_TYPE(TYPE)) u_dut (.clk(clk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(d_out), .sda_oe(d_oe), .select_pin_high(sel_hi),
    .select_pin_low(sel_lo), .write_protect(wp), .active(act));

  // Compare and count; a mismatch is reported at once.
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  function [7:0] sa(input page, input rw);
    sa = {TYPE, 2'b10, page, rw};
  endfunction

  // Send a byte; lvl is the slot level expected, low meaning acknowledged.
  task wr(input [7:0] b, input lvl);
    begin
      u_mst.xfer(b, 8, 1'b1, rd, a);
      check("ack slot", {7'h00, lvl}, {7'h00, a});
    end
  endtask

  // Read a byte, then acknowledge it when more are wanted.
  task rdb(input [7:0] exp, input more);
    begin
      u_mst.xfer(8'hFF, 8, !more, rd, a);
      check("read data", exp, rd);
    end
  endtask

  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // Stops a hung run long after the tests should have finished.
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    print_verdict;
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    u_mst.start_c;
    wr(sa(1'b1, 1'b0), 1'b0);
    wr(8'hFE, 1'b0);
    for (k = 8'hA1; k != 8'hE5; k = k + 8'h11) wr(k, 1'b0);
    u_mst.stop_c;
    $display("wrap write done");
    u_mst.start_c;
    wr(sa(1'b1, 1'b0), 1'b0);
    wr(8'hFE, 1'b0);
    u_mst.start_c;
    wr(sa(1'b1, 1'b1), 1'b0);
    for (k = 8'hA1; k != 8'hC3; k = k + 8'h11) rdb(k, 1'b1);
    rdb(8'hC3, 1'b0);
    u_mst.stop_c;
    check("active", 8'h00, {7'h00, act});
    u_mst.start_c;
    wr(sa(1'b0, 1'b1), 1'b0);
    rdb(8'hD4, 1'b0);
    u_mst.stop_c;
    $display("random and current read done");
    @(posedge clk) wp <= 1'b1;
    u_mst.start_c;
    wr(sa(1'b0, 1'b0), 1'b0);
    wr(8'h10, 1'b0);
    wr(8'h5A, 1'b0);
    u_mst.start_c;
    wr(sa(1'b1, 1'b0), 1'b0);
    wr(8'hFE, 1'b0);
    wr(8'h77, 1'b1);
    u_mst.stop_c;
    @(posedge clk) wp <= 1'b0;
    u_mst.start_c;
    wr(sa(1'b1, 1'b1), 1'b0);
    rdb(8'hA1, 1'b0);
    u_mst.stop_c;
    $display("write protect done");
    u_mst.start_c;
    wr(sa(1'b0, 1'b0), 1'b0);
    wr(8'h00, 1'b0);
    u_mst.xfer(8'h00, 4, 1'b1, rd, a);
    u_mst.stop_c;
    u_mst.start_c;
    wr(sa(1'b0, 1'b0), 1'b0);
    wr(8'h00, 1'b0);
    u_mst.start_c;
    wr(sa(1'b0, 1'b1), 1'b0);
    rdb(8'hC3, 1'b0);
    u_mst.stop_c;
    $display("partial byte abort done");
    u_mst.start_c;
    wr({TYPE ^ 4'h8, 3'b100, 1'b1}, 1'b1);
    check("active", 8'h00, {7'h00, act});
    u_mst.stop_c;
    u_mst.start_c;
    wr({TYPE, 3'b010, 1'b1}, 1'b1);
    u_mst.stop_c;
    $display("address mismatch done");
    // Swapped straps must move the match; reads back the lower-half byte written under protect.
    @(posedge clk) sel_hi <= 1'b0;
    sel_lo <= 1'b1;
    u_mst.start_c;
    wr({TYPE, 2'b01, 1'b0, 1'b0}, 1'b0);
    wr(8'h10, 1'b0);
    u_mst.start_c;
    wr({TYPE, 2'b01, 1'b0, 1'b1}, 1'b0);
    rdb(8'h5A, 1'b0);
    u_mst.stop_c;
    $display("select pins done");
    print_verdict;
  end
endmodule  // nvs_slave_tb_top

// >>> src/nvs_defines.vh
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH

// ****************************************************************
// Slave address byte layout
// ****************************************************************
`define NVS_TYPE_MSB      7
`define NVS_TYPE_LSB      4
`define NVS_SEL_HI_BIT    3
`define NVS_SEL_LO_BIT    2
`define NVS_PAGE_BIT      1
`define NVS_RW_BIT        0

// ****************************************************************
// Memory geometry and reset values
// ****************************************************************
`define NVS_ADDR_W        9
`define NVS_DATA_W        8
`define NVS_ADDR_RESET    9'h000
`define NVS_BYTE_RESET    8'h00

// ****************************************************************
// Bit counting within one byte plus its acknowledge slot
// ****************************************************************
`define NVS_LAST_DATA_BIT 4'h7
`define NVS_ACK_SLOT      4'h8
`define NVS_CNT_RESET     4'h0

// ****************************************************************
// Read buffer occupancy
// ****************************************************************
`define NVS_BUF_FULL      2'h2
`define NVS_BUF_EMPTY     2'h0

`endif

// >>> src/nvs_slave.v
`timescale 1ns/10ps
`include "nvs_defines.vh"

module nvs_slave #(
  parameter [3:0] DEV_TYPE = 4'h5,  // Arbitrary device type code, set per product.
  parameter       DATA_W   = 8,
  parameter       ADDR_W   = 9
) (
  input  wire clk,
  input  wire reset_n,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe,
  input  wire select_pin_high,
  input  wire select_pin_low,
  input  wire write_protect,
  output reg  active
);

  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV  = 3'h1;
  localparam [2:0] ST_WORD = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg rst_meta;
  reg rst_n;

  // Reset is applied at once but released through two flops so that
  // no flop leaves reset on a different edge from its neighbours.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg  [4:0] pin_meta;
  reg  [4:0] pin_sync;
  reg        scl_d;
  reg        sda_d;
  wire       scl_s = pin_sync[1];
  wire       sda_s = pin_sync[0];
  wire       wp_s  = pin_sync[4];
  wire       hi_s  = pin_sync[3];
  wire       lo_s  = pin_sync[2];

  // Every pin passes two flops; the first copy is never looked at.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 5'h03;
      pin_sync <= 5'h03;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      pin_meta <= {write_protect, select_pin_high, select_pin_low, scl_in, sda_in};
      pin_sync <= pin_meta;
      scl_d    <= scl_s;
      sda_d    <= sda_s;
    end
  end

  // Start and stop are data edges while the clock stays high.
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // Protocol registers
  // ****************************************************************
  reg [2:0]        state;
  reg [3:0]        bit_cnt;
  reg              ack_phase;
  reg [DATA_W-1:0] shreg;
  reg [DATA_W-1:0] txreg;
  reg [ADDR_W-1:0] addr;
  reg              page;
  reg              rw;
  reg              pf_run;
  reg [ADDR_W-1:0] pf_addr;

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Byte as it stands once the current sample is shifted in.
  wire [DATA_W-1:0] rx_byte = {shreg[DATA_W-2:0], sda_s};
  wire last_rx = scl_rise & (bit_cnt == `NVS_LAST_DATA_BIT) & ~ack_phase;
  wire abort   = bus_start | bus_stop;

  // Address match uses the type code and both select straps.
  wire dev_match = (rx_byte[`NVS_TYPE_MSB:`NVS_TYPE_LSB] == DEV_TYPE) &
                   (rx_byte[`NVS_SEL_HI_BIT] == hi_s) &
                   (rx_byte[`NVS_SEL_LO_BIT] == lo_s);

  wire protected_wr = wp_s & addr[ADDR_W-1];
  wire wr_fire = (state == ST_WR) & last_rx & ~abort & ~protected_wr;

  // ****************************************************************
  // Two-entry read buffer
  // ****************************************************************
  reg [DATA_W-1:0] buf_mem [0:1];
  reg              buf_wp;
  reg              buf_rp;
  reg [1:0]        buf_cnt;
  reg              buf_flush;

  // The fill side prefetches ahead of the shifter; its ready stalls
  // the prefetch address, so a slow drain never drops a byte.
  wire buf_in_ready  = (buf_cnt != `NVS_BUF_FULL);
  wire buf_in_valid  = pf_run & ~buf_flush;
  wire buf_push      = buf_in_valid & buf_in_ready;
  wire buf_out_valid = (buf_cnt != `NVS_BUF_EMPTY);
  wire [DATA_W-1:0] buf_head = buf_mem[buf_rp];

  // The shifter takes a byte at the fall that ends an acknowledge.
  wire tx_load  = scl_fall & ack_phase & ~abort &
                  (((state == ST_DEV) & rw) | (state == ST_RD));
  wire buf_pop  = tx_load & buf_out_valid;

  // Buffer pointers; a flush wins so stale prefetches are discarded.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= `NVS_BUF_EMPTY;
    end else if (buf_flush) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= `NVS_BUF_EMPTY;
    end else begin
      if (buf_push) begin
        buf_wp <= ~buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= ~buf_rp;
      end
      case ({buf_push, buf_pop})
        2'h2:    buf_cnt <= buf_cnt + 2'h1;
        2'h1:    buf_cnt <= buf_cnt - 2'h1;
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end

  // Buffer storage and the memory array carry no reset.
  always @(posedge clk) begin
    if (buf_push) begin
      buf_mem[buf_wp] <= mem[pf_addr];
    end
    if (wr_fire) begin
      mem[addr] <= rx_byte;
    end
  end

  // ****************************************************************
  // Prefetch address
  // ****************************************************************
  // Prefetch restarts at the current read address when a read is
  // addressed and stops at the end of any operation.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_run    <= 1'b0;
      pf_addr   <= `NVS_ADDR_RESET;
      buf_flush <= 1'b1;
    end else if (abort || state == ST_IDLE) begin
      pf_run    <= 1'b0;
      buf_flush <= 1'b1;
    end else if (state == ST_DEV && last_rx && dev_match &&
                 rx_byte[`NVS_RW_BIT]) begin
      pf_run    <= 1'b1;
      pf_addr   <= {rx_byte[`NVS_PAGE_BIT], addr[ADDR_W-2:0]};
      buf_flush <= 1'b1;
    end else begin
      buf_flush <= 1'b0;
      if (buf_push) begin
        pf_addr <= pf_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  // Start and stop take priority over any bit activity, so a write
  // aborted before its eighth bit never reaches the array.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= `NVS_CNT_RESET;
      ack_phase <= 1'b0;
      shreg     <= `NVS_BYTE_RESET;
      txreg     <= `NVS_BYTE_RESET;
      addr      <= `NVS_ADDR_RESET;
      page      <= 1'b0;
      rw        <= 1'b0;
      sda_oe    <= 1'b0;
      active    <= 1'b0;
    end else if (bus_start) begin
      state     <= ST_DEV;
      bit_cnt   <= `NVS_CNT_RESET;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
      active    <= 1'b1;
    end else if (bus_stop) begin
      state     <= ST_IDLE;
      bit_cnt   <= `NVS_CNT_RESET;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
      active    <= 1'b0;
    end else begin
      case (state)
        ST_DEV, ST_WORD, ST_WR: begin
          // Receive side: sample while clock is high, ack on the ninth clock.
          if (scl_rise && !ack_phase && bit_cnt < `NVS_ACK_SLOT) begin
            shreg   <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (last_rx) begin
            case (state)
              ST_DEV: begin
                if (dev_match) begin
                  page <= rx_byte[`NVS_PAGE_BIT];
                  rw   <= rx_byte[`NVS_RW_BIT];
                  if (rx_byte[`NVS_RW_BIT]) begin
                    addr[ADDR_W-1] <= rx_byte[`NVS_PAGE_BIT];
                  end
                end else begin
                  state  <= ST_IDLE;
                  active <= 1'b0;
                end
              end
              ST_WORD: begin
                addr <= {page, rx_byte};
              end
              default: begin
                if (protected_wr) begin
                  state  <= ST_IDLE;
                  active <= 1'b0;
                end else begin
                  addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                end
              end
            endcase
          end
          if (scl_fall && bit_cnt == `NVS_ACK_SLOT) begin
            if (!ack_phase) begin
              ack_phase <= 1'b1;
              sda_oe    <= 1'b1;
            end else begin
              ack_phase <= 1'b0;
              bit_cnt   <= `NVS_CNT_RESET;
              case (state)
                ST_DEV: begin
                  if (rw) begin
                    state  <= ST_RD;
                    txreg  <= buf_head;
                    sda_oe <= ~buf_head[DATA_W-1];
                  end else begin
                    state  <= ST_WORD;
                    sda_oe <= 1'b0;
                  end
                end
                default: begin
                  state  <= ST_WR;
                  sda_oe <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_RD: begin
          // Transmit side: master samples on rises, we shift after falls.
          if (scl_rise) begin
            if (bit_cnt < `NVS_ACK_SLOT) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (!ack_phase) begin
              if (!sda_s) begin
                ack_phase <= 1'b1;
              end else begin
                state  <= ST_IDLE;
                active <= 1'b0;
              end
            end
          end
          if (scl_fall) begin
            if (ack_phase) begin
              ack_phase <= 1'b0;
              bit_cnt   <= `NVS_CNT_RESET;
              txreg     <= buf_head;
              sda_oe    <= ~buf_head[DATA_W-1];
            end else if (bit_cnt == `NVS_ACK_SLOT) begin
              sda_oe <= 1'b0;
              addr   <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
            end else if (bit_cnt != `NVS_CNT_RESET) begin
              txreg  <= {txreg[DATA_W-2:0], 1'b0};
              sda_oe <= ~txreg[DATA_W-2];
            end
          end
        end
        default: begin
          // Idle: ignore bits until the next start, lines released.
          state     <= ST_IDLE;
          bit_cnt   <= `NVS_CNT_RESET;
          ack_phase <= 1'b0;
          sda_oe    <= 1'b0;
          active    <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Open-drain output
  // ****************************************************************
  // The data pin only ever pulls low; the enable alone carries the bit.
  assign sda_out = 1'b0;

endmodule // nvs_slave
